// ---- design/sqcsr_pkg.sv ----
// Purpose: Shared constants for the SERDES quad control and status registers
// Assumes: AHB-Lite word access, register byte address is four times its index
// Notes:   Field positions count from bit 0 as the least significant bit
package sqcsr_pkg;

  // ----------------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------------
  localparam logic [29:0] IDX_XAUI_STAT  = 30'h0003_0804;
  localparam logic [29:0] IDX_CHAR_CTRL  = 30'h0003_0830;
  localparam logic [29:0] IDX_BYP_CLKSEL = 30'h0003_0840;
  localparam logic [29:0] IDX_XAUI_ENA   = 30'h0003_0841;
  localparam logic [29:0] IDX_IRQ_STAT   = 30'h0003_0842;
  localparam logic [29:0] IDX_IRQ_MASK   = 30'h0003_0843;

  // ----------------------------------------------------------------------
  // Field positions, write masks and reset values
  // ----------------------------------------------------------------------
  localparam int          BYP_BIT      = 0;
  localparam int          RCK_LSB      = 4;
  localparam int          TCK_LSB      = 6;
  localparam int          CHAR_ENA_BIT = 4;
  localparam int          CHAR_TX_BIT  = 5;
  localparam int          CHAR_CH_LSB  = 6;
  localparam int          XMODE_BIT    = 0;
  localparam logic [7:0]  BYP_WMASK    = 8'hF1;
  localparam logic [7:0]  CHAR_WMASK   = 8'hF0;
  localparam logic [7:0]  REG8_RESET   = 8'h00;
  localparam logic [3:0]  REG4_RESET   = 4'h0;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
  localparam logic [1:0]  TEST_MODE_OK = 2'h0;
  localparam logic [1:0]  XAUI_SYNCED  = 2'h2;

  // Clock source select codes
  localparam logic [1:0]  CLK_SEL_A    = 2'h0;
  localparam logic [1:0]  CLK_SEL_B    = 2'h2;
  localparam logic [1:0]  CLK_SEL_C    = 2'h1;
  localparam logic [1:0]  CLK_SEL_D    = 2'h3;

  // Channel counts and pin widths
  localparam int          NUM_CH       = 4;
  localparam int          LDATA_W      = 10;
  localparam int          OBS_W        = 16;
  localparam int          STIM_W       = 11;

  // Bus slave phase
  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_DATA = 1'b1
  } sqcsr_bus_state_type;

endpackage

// ---- design/sqcsr_regs.sv ----
// What this block does
// R1: Bypass bit routes data around alignment FIFOs
// R2: Bypass bit clears on reset
// R3: Rx clock source select, 00 A 10 B
// R4: Tx clock source select, same code
// R5: Char enable bit starts characterization, resets zero
// R6: System holds test inputs 00, SPI4 low
// R7: Char mode drives chosen channel onto observation pins
// R8: Tx select bit drives channel tx from pins
// R9: Tester clock and data forwarded to channel
// R10: Char channel field picks A to D
// R11: Read-only per-channel XAUI link state
// R12: XAUI state reads 00 after reset
// R13: Quad_xaui_machine_enable bit enables quad XAUI machines
// R14: Reserved bits ignore writes, read zero
//
// Purpose: Control and status registers of a four-channel SERDES quad
// Assumes: One clock; SERDES and pin inputs are asynchronous to it
// Notes:   Every access has one wait state so read data leaves a flop
`timescale 1ns/1ns

module sqcsr_regs
  import sqcsr_pkg::*;
(
  input  wire logic                       ref_clk,
  input  wire logic                       rst_n,
  // AHB-Lite slave
  input  wire logic                       hsel,
  input  wire logic [31:0]                haddr,
  input  wire logic [1:0]                 htrans,
  input  wire logic                       hwrite,
  input  wire logic [2:0]                 hsize,
  input  wire logic [31:0]                hwdata,
  input  wire logic                       hready,
  output logic                            hreadyout,
  output logic                            hresp,
  output logic [31:0]                     hrdata,
  output logic                            irq,
  // SERDES channel side, channel A in the lowest bits
  input  wire logic [NUM_CH-1:0]          tx_byte_clock_observe,
  input  wire logic [NUM_CH-1:0]          code_violation_observe,
  input  wire logic [NUM_CH-1:0]          byte_sync_observe,
  input  wire logic [NUM_CH-1:0]          word_sync_observe,
  input  wire logic [NUM_CH-1:0]          rx_byte_clock0_observe,
  input  wire logic [NUM_CH-1:0]          rx_byte_clock1_observe,
  input  wire logic [NUM_CH*LDATA_W-1:0]  rx_low_speed_data,
  input  wire logic [2*NUM_CH-1:0]        xaui_link_state,
  output logic                            align_fifo_bypass,
  output logic                            quad_xaui_machine_enable,
  output logic [NUM_CH-1:0]               rx_clk_src_onehot,
  output logic [NUM_CH-1:0]               tx_clk_src_onehot,
  output logic [NUM_CH-1:0]               char_tx_chan_onehot,
  output logic                            char_tx_byte_clock,
  output logic [LDATA_W-1:0]              tx_low_speed_data,
  // Device pins
  input  wire logic [1:0]                 test_mode_inputs_n,
  input  wire logic                       fabric_spi4_enable_n,
  input  wire logic [STIM_W-1:0]          stimulus_pins,
  output logic [OBS_W-1:0]                observation_pins
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int SYNC_W  = NUM_CH * OBS_W + 2 * NUM_CH + STIM_W + 3;
  localparam int OBS_LSB = 3 + STIM_W + 2 * NUM_CH;
  sqcsr_bus_state_type    bus_q;
  logic [29:0]            idx_q;
  logic [31:0]            hrdata_q, rd_mux;
  logic [7:0]             byp_reg_q, char_reg_q, xaui_prev_q, xaui_view;
  logic [3:0]             irq_stat_q, irq_mask_q, irq_set, irq_clr;
  logic                   wr_q, hreadyout_q, hresp_q, xmode_q, irq_q, seen_q;
  logic                   char_active, char_tx_active, acc_ok, wr_en, spi4_n_s, tx_bclk_q;
  logic [SYNC_W-1:0]      s1_q, s2_q, s3_q, stable_q, raw_in;
  logic [NUM_CH*OBS_W-1:0] obs_all;
  logic [OBS_W-1:0]       obs_sel, obs_q;
  logic [STIM_W-1:0]      stim_s;
  logic [1:0]             tmode_s;
  logic [NUM_CH-1:0]      rx_clk_q, tx_clk_q, tx_chan_q;
  logic [LDATA_W-1:0]     tx_data_q;
  // Decode a clock source code into a one-hot channel vector
  function automatic logic [NUM_CH-1:0] clk_sel_dec(input logic [1:0] code);
    logic [NUM_CH-1:0] res;
    res = 4'h0;
    case (code)
      CLK_SEL_A: res = 4'h1;
      CLK_SEL_B: res = 4'h2;
      CLK_SEL_C: res = 4'h4;
      CLK_SEL_D: res = 4'h8;
      default:   res = 4'h0;
    endcase
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  // Channel words: tx clock, violation, syncs, rx clocks, data[9:0], per channel
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      obs_all[c*OBS_W +: OBS_W] = {tx_byte_clock_observe[c], code_violation_observe[c],
                                   byte_sync_observe[c], word_sync_observe[c],
                                   rx_byte_clock0_observe[c], rx_byte_clock1_observe[c],
                                   rx_low_speed_data[c*LDATA_W +: LDATA_W]};
    end
  end

  assign raw_in = {obs_all, xaui_link_state, stimulus_pins, test_mode_inputs_n,
                   fabric_spi4_enable_n};
  // Three flops; a value is taken once stages two and three agree
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q     <= '0;
      s2_q     <= '0;
      s3_q     <= '0;
      stable_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < SYNC_W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          stable_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign spi4_n_s  = stable_q[0];
  assign tmode_s   = stable_q[2:1];
  assign stim_s    = stable_q[3 +: STIM_W];
  assign xaui_view = xmode_q ? stable_q[3+STIM_W +: 2*NUM_CH] : REG8_RESET; // R13 R12

  // ----------------------------------------------------------------------
  // AHB-Lite slave: address phase, then one wait state, then data
  // ----------------------------------------------------------------------
  assign acc_ok = hsel && hready && (htrans == HTRANS_NSEQ);
  assign wr_en  = (bus_q == BUS_DATA) && wr_q;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q       <= BUS_IDLE;
      idx_q       <= '0;
      wr_q        <= 1'b0;
      hreadyout_q <= 1'b1;
      hresp_q     <= 1'b0;
    end else begin
      case (bus_q)
        BUS_IDLE: begin
          if (acc_ok) begin
            bus_q       <= BUS_DATA;
            idx_q       <= (haddr[1:0] == 2'h0) ? haddr[31:2] : 30'h0;
            wr_q        <= hwrite;
            hreadyout_q <= 1'b0;
          end
        end
        BUS_DATA: begin
          bus_q       <= BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
        default: begin
          bus_q       <= BUS_IDLE;
          hreadyout_q <= 1'b1;
        end
      endcase
    end
  end

  // Read multiplexer; unmapped and reserved bits read zero
  always_comb begin
    rd_mux = 32'h0;
    case (idx_q)
      IDX_XAUI_STAT:  rd_mux[7:0] = xaui_view;                   // R11
      IDX_CHAR_CTRL:  rd_mux[7:0] = char_reg_q & CHAR_WMASK;    // R14
      IDX_BYP_CLKSEL: rd_mux[7:0] = byp_reg_q & BYP_WMASK;      // R14
      IDX_XAUI_ENA:   rd_mux[XMODE_BIT] = xmode_q;
      IDX_IRQ_STAT:   rd_mux[3:0] = irq_stat_q;
      IDX_IRQ_MASK:   rd_mux[3:0] = irq_mask_q;
      default:        rd_mux = 32'h0;
    endcase
  end

  // Read data leaves a flop at the end of the wait state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0;
    end else if (bus_q == BUS_DATA && !wr_q) begin
      hrdata_q <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      byp_reg_q  <= REG8_RESET;                                  // R2
      char_reg_q <= REG8_RESET;                                  // R5
      xmode_q    <= 1'b0;
      irq_mask_q <= REG4_RESET;
    end else if (wr_en) begin
      case (idx_q)
        IDX_BYP_CLKSEL: byp_reg_q  <= hwdata[7:0] & BYP_WMASK;   // R1 R14
        IDX_CHAR_CTRL:  char_reg_q <= hwdata[7:0] & CHAR_WMASK;  // R5 R14
        IDX_XAUI_ENA:   xmode_q    <= hwdata[XMODE_BIT];         // R13
        IDX_IRQ_MASK:   irq_mask_q <= hwdata[3:0];
        default:        ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Link events: a channel reaching sync sets a sticky bit
  // ----------------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      irq_set[c] = (xaui_view[2*c +: 2] == XAUI_SYNCED) &&
                   (xaui_prev_q[2*c +: 2] != XAUI_SYNCED);
    end
    irq_clr = (wr_en && idx_q == IDX_IRQ_STAT) ? hwdata[3:0] : 4'h0;
  end

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      xaui_prev_q <= REG8_RESET;
      irq_stat_q  <= REG4_RESET;
      irq_q       <= 1'b0;
    end else begin
      xaui_prev_q <= xaui_view;
      irq_stat_q  <= (irq_stat_q & ~irq_clr) | irq_set;
      irq_q       <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ----------------------------------------------------------------------
  // Clock source selects and characterization path
  // ----------------------------------------------------------------------
  assign char_active    = char_reg_q[CHAR_ENA_BIT] && (tmode_s == TEST_MODE_OK) &&
                          !spi4_n_s;                                       // R6
  assign char_tx_active = char_active && char_reg_q[CHAR_TX_BIT];
  assign obs_sel        = stable_q[OBS_LSB + OBS_W*char_reg_q[CHAR_CH_LSB +: 2] +: OBS_W]; // R10

  // Registered clock source one-hots and characterization pin paths
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_clk_q  <= '0;
      tx_clk_q  <= '0;
      tx_chan_q <= '0;
      tx_bclk_q <= 1'b0;
      tx_data_q <= '0;
      obs_q     <= '0;
    end else begin
      rx_clk_q <= clk_sel_dec(byp_reg_q[RCK_LSB +: 2]);                  // R3
      tx_clk_q <= clk_sel_dec(byp_reg_q[TCK_LSB +: 2]);                  // R4
      obs_q    <= char_active ? obs_sel : '0;                             // R7
      if (char_tx_active) begin
        tx_chan_q <= 4'h1 << char_reg_q[CHAR_CH_LSB +: 2];                // R8 R10
        tx_bclk_q <= stim_s[STIM_W-1];                                    // R9
        tx_data_q <= stim_s[LDATA_W-1:0];                                 // R9
      end else begin
        tx_chan_q <= '0;
        tx_bclk_q <= 1'b0;
        tx_data_q <= '0;
      end
    end
  end

  // Marks cycles after the first one out of reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_q <= 1'b0;
    end else begin
      seen_q <= 1'b1;
    end
  end

  assign hreadyout                = hreadyout_q;
  assign hresp                    = hresp_q;
  assign hrdata                   = hrdata_q;
  assign irq                      = irq_q;
  assign align_fifo_bypass        = byp_reg_q[BYP_BIT];                 // R1
  assign quad_xaui_machine_enable = xmode_q;                             // R13
  assign rx_clk_src_onehot        = rx_clk_q;
  assign tx_clk_src_onehot        = tx_clk_q;
  assign char_tx_chan_onehot      = tx_chan_q;
  assign char_tx_byte_clock       = tx_bclk_q;
  assign tx_low_speed_data        = tx_data_q;
  assign observation_pins         = obs_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_addr_to(logic [29:0] idx, logic wr);
    acc_ok && haddr[31:2] == idx && haddr[1:0] == 2'h0 && hwrite == wr && bus_q == BUS_IDLE;
  endsequence
  sequence s_xaui_read;
    s_addr_to(IDX_XAUI_STAT, 1'b0) ##1 (bus_q == BUS_DATA);
  endsequence
  a_bypass_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    s_addr_to(IDX_BYP_CLKSEL, 1'b1) ##1 1'b1 |=> align_fifo_bypass == $past(hwdata[BYP_BIT]))
    else $error("bypass bit did not take written value");
  a_bypass_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    !seen_q |-> !align_fifo_bypass)
    else $error("bypass bit not clear after reset");
  a_rx_sel_map: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    seen_q |-> rx_clk_src_onehot == clk_sel_dec($past(byp_reg_q[RCK_LSB +: 2])))
    else $error("rx clock source select wrong");
  a_tx_sel_map: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    seen_q && $past(byp_reg_q[TCK_LSB +: 2]) == CLK_SEL_D |-> tx_clk_src_onehot == 4'h8)
    else $error("tx clock source select wrong");
  a_char_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    !seen_q |-> !char_reg_q[CHAR_ENA_BIT] && observation_pins == '0)
    else $error("char enable not clear after reset");
  a_obs_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // R7
    !char_active |=> observation_pins == '0)
    else $error("observation pins driven outside char mode");
  a_tx_drive_on: assert property (@(posedge ref_clk) disable iff (!rst_n) // R8
    char_tx_active [*2] |-> char_tx_chan_onehot != '0)
    else $error("tx drive not applied");
  a_tx_forward: assert property (@(posedge ref_clk) disable iff (!rst_n) // R9
    char_tx_active |=> tx_low_speed_data == $past(stim_s[LDATA_W-1:0]))
    else $error("stimulus data not forwarded");
  a_chan_pick: assert property (@(posedge ref_clk) disable iff (!rst_n) // R10
    char_tx_active && char_reg_q[CHAR_CH_LSB +: 2] == 2'h1 |=> char_tx_chan_onehot == 4'h2)
    else $error("char channel select wrong");
  a_xaui_read: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
    s_xaui_read |=> hrdata[7:0] == $past(xaui_view) && hreadyout)
    else $error("xaui status read wrong");
  a_xaui_reset: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
    !seen_q |-> xaui_view == REG8_RESET)
    else $error("xaui status not zero after reset");
  a_xaui_gate: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
    !quad_xaui_machine_enable |-> xaui_view == REG8_RESET)
    else $error("xaui status shown with machines off");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    s_addr_to(IDX_CHAR_CTRL, 1'b0) ##1 1'b1 |=> hrdata[3:0] == 4'h0)
    else $error("reserved bits read nonzero");
endmodule

// ---- verif/sqcsr_quad_model.sv ----
// Purpose: Behavioural SERDES quad and tester pins facing the register block
// Assumes: Each channel shows fixed observation levels so every channel is told apart
// Notes:   Test pins allow characterization only while the bench asks for it
`timescale 1ns/1ns

module sqcsr_quad_model
  import sqcsr_pkg::*;
#(
  parameter logic [3:0]  TXC = 4'h9,
  parameter logic [3:0]  VIO = 4'h3,
  parameter logic [3:0]  BS  = 4'h5,
  parameter logic [3:0]  WS  = 4'hC,
  parameter logic [3:0]  RB0 = 4'h6,
  parameter logic [3:0]  RB1 = 4'hA,
  parameter logic [39:0] LD  = 40'h12345_6789A
)(
  input  wire logic                       char_ok,
  input  wire logic [STIM_W-1:0]          stim_cmd,
  input  wire logic [7:0]                 link_cmd,
  output logic [NUM_CH-1:0]               tx_byte_clock_observe,
  output logic [NUM_CH-1:0]               code_violation_observe,
  output logic [NUM_CH-1:0]               byte_sync_observe,
  output logic [NUM_CH-1:0]               word_sync_observe,
  output logic [NUM_CH-1:0]               rx_byte_clock0_observe,
  output logic [NUM_CH-1:0]               rx_byte_clock1_observe,
  output logic [NUM_CH*LDATA_W-1:0]       rx_low_speed_data,
  output logic [2*NUM_CH-1:0]             xaui_link_state,
  output logic [1:0]                      test_mode_inputs_n,
  output logic                            fabric_spi4_enable_n,
  output logic [STIM_W-1:0]               stimulus_pins
);
  // ----------------------------------------------------------------------
  // Channel side levels
  // ----------------------------------------------------------------------
  // Per-channel observation levels, channel A in bit 0
  assign tx_byte_clock_observe  = TXC;
  assign code_violation_observe = VIO;
  assign byte_sync_observe      = BS;
  assign word_sync_observe      = WS;
  assign rx_byte_clock0_observe = RB0;
  assign rx_byte_clock1_observe = RB1;
  assign rx_low_speed_data      = LD;
  assign xaui_link_state        = link_cmd;

  // ----------------------------------------------------------------------
  // Tester pins
  // ----------------------------------------------------------------------
  // Both test inputs low and SPI4 enable low only when allowed
  assign test_mode_inputs_n   = char_ok ? TEST_MODE_OK : 2'h1;
  assign fabric_spi4_enable_n = ~char_ok;
  assign stimulus_pins        = stim_cmd;
endmodule

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the SERDES quad control and status registers
// Assumes: One AHB-Lite master, hready taken from the slave's hreadyout
// Notes:   Pin inputs pass a synchronizer, so checks wait eight cycles
`timescale 1ns/1ns

module tb_top
  import sqcsr_pkg::*;
;
  localparam logic [3:0]  P_TXC = 4'h9;
  localparam logic [3:0]  P_VIO = 4'h3;
  localparam logic [3:0]  P_BS  = 4'h5;
  localparam logic [3:0]  P_WS  = 4'hC;
  localparam logic [3:0]  P_RB0 = 4'h6;
  localparam logic [3:0]  P_RB1 = 4'hA;
  localparam logic [39:0] P_LD  = 40'h12345_6789A;
  localparam logic [31:0] A_XS  = {IDX_XAUI_STAT, 2'h0};
  localparam logic [31:0] A_CH  = {IDX_CHAR_CTRL, 2'h0};
  localparam logic [31:0] A_BC  = {IDX_BYP_CLKSEL, 2'h0};
  localparam logic [31:0] A_XM  = {IDX_XAUI_ENA, 2'h0};
  localparam logic [31:0] A_IS  = {IDX_IRQ_STAT, 2'h0};
  localparam logic [31:0] A_IM  = {IDX_IRQ_MASK, 2'h0};
  localparam logic [31:0] A_NO  = 32'h000C_2200;

  logic                        ref_clk, rst_n, hwrite, char_ok;
  logic [1:0]                  htrans, c;
  logic [31:0]                 haddr, hwdata, rd;
  logic [STIM_W-1:0]           stim_cmd;
  logic [7:0]                  link_cmd;
  logic                        hreadyout, hresp, irq, align_fifo_bypass;
  logic                        quad_xaui_machine_enable, char_tx_byte_clock;
  logic                        fabric_spi4_enable_n;
  logic [31:0]                 hrdata;
  logic [3:0]                  rx_clk_src_onehot, tx_clk_src_onehot, char_tx_chan_onehot;
  logic [3:0]                  tx_byte_clock_observe, code_violation_observe;
  logic [3:0]                  byte_sync_observe, word_sync_observe;
  logic [3:0]                  rx_byte_clock0_observe, rx_byte_clock1_observe;
  logic [39:0]                 rx_low_speed_data;
  logic [7:0]                  xaui_link_state;
  logic [1:0]                  test_mode_inputs_n;
  logic [LDATA_W-1:0]          tx_low_speed_data;
  logic [STIM_W-1:0]           stimulus_pins;
  logic [OBS_W-1:0]            observation_pins;
  logic [31:0]                 regs [6];
  int                          fails = 0;
  int                          compares = 0;
  int                          cyc = 0;

  // ----------------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------------
  sqcsr_regs i_dut (
    .ref_clk, .rst_n, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .irq, .tx_byte_clock_observe,
    .code_violation_observe, .byte_sync_observe, .word_sync_observe,
    .rx_byte_clock0_observe, .rx_byte_clock1_observe, .rx_low_speed_data,
    .xaui_link_state, .align_fifo_bypass, .quad_xaui_machine_enable, .rx_clk_src_onehot,
    .tx_clk_src_onehot, .char_tx_chan_onehot, .char_tx_byte_clock, .tx_low_speed_data,
    .test_mode_inputs_n, .fabric_spi4_enable_n, .stimulus_pins, .observation_pins);

  sqcsr_quad_model #(.TXC(P_TXC), .VIO(P_VIO), .BS(P_BS), .WS(P_WS), .RB0(P_RB0),
    .RB1(P_RB1), .LD(P_LD)) i_quad (
    .char_ok, .stim_cmd, .link_cmd, .tx_byte_clock_observe, .code_violation_observe,
    .byte_sync_observe, .word_sync_observe, .rx_byte_clock0_observe,
    .rx_byte_clock1_observe, .rx_low_speed_data, .xaui_link_state,
    .test_mode_inputs_n, .fabric_spi4_enable_n, .stimulus_pins);

  // ----------------------------------------------------------------------
  // Clock, timeout and report
  // ----------------------------------------------------------------------
  // Free running 50 ns clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Cuts a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // One single transfer; entered and left just after a rising edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr  <= a;
    hwrite <= w;
    htrans <= HTRANS_NSEQ;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rdc(input logic [31:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(rd, e);
  endtask

  // Clock source code to one-hot channel, A in bit 0
  function automatic logic [3:0] oh(input logic [1:0] s);
    return 4'h1 << {s[0], s[1]};
  endfunction

  function automatic logic [15:0] obs(input int k);
    return {P_TXC[k], P_VIO[k], P_BS[k], P_WS[k], P_RB0[k], P_RB1[k], P_LD[10*k+:10]};
  endfunction

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst_n = 1'b0; htrans = 2'h0; haddr = 32'h0; hwrite = 1'b0; hwdata = 32'h0;
    char_ok = 1'b0; stim_cmd = 11'h4B6; link_cmd = 8'h00;
    regs = '{A_XS, A_CH, A_BC, A_XM, A_IS, A_IM};
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    // Reset values
    for (int i = 0; i < 6; i++) rdc(regs[i], 32'h0);
    chk(align_fifo_bypass, 32'h0);
    chk(rx_clk_src_onehot, 32'h1);
    chk(tx_clk_src_onehot, 32'h1);
    chk(observation_pins, 32'h0);
    // Every clock source code on both selects, reserved bits set
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr(A_BC, {24'h0, ~c, c, 4'hF});
      tick(2);
      chk(align_fifo_bypass, 32'h1);
      chk(rx_clk_src_onehot, oh(c));
      chk(tx_clk_src_onehot, oh(~c));
      rdc(A_BC, {24'h0, ~c, c, 4'h1});
    end
    wr(A_BC, 32'h0);
    chk(align_fifo_bypass, 32'h0);
    wr(A_BC | 32'h2, 32'hF1);
    rdc(A_BC, 32'h0);
    wr(A_NO, 32'hFF);
    rdc(A_NO, 32'h0);
    // Characterization on each channel with tester drive
    char_ok <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      wr(A_CH, {24'h0, c, 2'h3, 4'hF});
      tick(8);
      chk(observation_pins, obs(k));
      chk(char_tx_chan_onehot, 32'h1 << k);
      chk({char_tx_byte_clock, tx_low_speed_data}, stim_cmd);
      rdc(A_CH, {24'h0, c, 2'h3, 4'h0});
    end
    stim_cmd <= 11'h349;
    tick(8);
    chk({char_tx_byte_clock, tx_low_speed_data}, 32'h349);
    wr(A_CH, 32'h50);
    tick(8);
    chk(char_tx_chan_onehot, 32'h0);
    chk(tx_low_speed_data, 32'h0);
    chk(observation_pins, obs(1));
    char_ok <= 1'b0;
    tick(8);
    chk(observation_pins, 32'h0);
    // Link state stays hidden until the quad machines are on
    link_cmd <= 8'hE4;
    wr(A_XS, 32'hFF);
    tick(8);
    rdc(A_XS, 32'h0);
    wr(A_XM, 32'h1);
    chk(quad_xaui_machine_enable, 32'h1);
    tick(8);
    rdc(A_XS, 32'hE4);
    // Sync event on channel B, masked then unmasked, then cleared
    wr(A_IS, 32'hF);
    link_cmd <= 8'h00;
    tick(8);
    rdc(A_IS, 32'h0);
    link_cmd <= 8'h08;
    tick(8);
    rdc(A_IS, 32'h2);
    chk(irq, 32'h0);
    wr(A_IM, 32'h2);
    tick(2);
    chk(irq, 32'h1);
    wr(A_IS, 32'h2);
    tick(2);
    chk(irq, 32'h0);
    rdc(A_IS, 32'h0);
    wrap_up();
  end
endmodule
